// *** pkg/fcs_pkg.sv ***
// constants, types and state layout of the flash command sequencer
// assumes a 16-bit cpu write/read port and an external flash array macro
package fcs_pkg;

    localparam int ADDR_W       = 19;
    localparam int BLOCK_SHIFT  = 16;
    localparam int NUM_BLOCKS   = 8;
    localparam int BLK_W        = 3;
    localparam int PAGE_WORDS   = 128;
    localparam int PAGE_IDX_W   = 7;
    localparam int PAGE_SHIFT   = 8;
    localparam int CODE_W       = 8;

    localparam logic [BLOCK_SHIFT-1:0] BLOCK_TOP_OFS = 16'hfffe;
    localparam logic [7:0]             PAGE_LAST     = 8'h7f;

    // command codes, low byte only; the high byte is ignored
    localparam logic [CODE_W-1:0] CMD_READ_ARRAY  = 8'hff;
    localparam logic [CODE_W-1:0] CMD_READ_STATUS = 8'h70;
    localparam logic [CODE_W-1:0] CMD_CLEAR_STAT  = 8'h50;
    localparam logic [CODE_W-1:0] CMD_PAGE_PROG   = 8'h41;
    localparam logic [CODE_W-1:0] CMD_BLOCK_ERASE = 8'h20;
    localparam logic [CODE_W-1:0] CMD_ERASE_ALL   = 8'ha7;
    localparam logic [CODE_W-1:0] CMD_LOCK_PROG   = 8'h77;
    localparam logic [CODE_W-1:0] CMD_READ_LOCK   = 8'h71;
    localparam logic [CODE_W-1:0] CMD_CONFIRM     = 8'hd0;

    // status register and lock read data bit positions
    localparam int ST_EXCESS_BIT = 3;
    localparam int ST_PROG_BIT   = 4;
    localparam int ST_ERASE_BIT  = 5;
    localparam int ST_READY_BIT  = 7;
    localparam int LOCK_DATA_BIT = 6;

    localparam logic [7:0] STATUS_RESET = 8'h80;

    typedef enum logic [1:0] {
        OP_PROGRAM,
        OP_ERASE,
        OP_LOCK
    } fcs_op_t;

    typedef enum logic [2:0] {
        MODE_ARRAY,
        MODE_STATUS,
        MODE_LOCK,
        MODE_PAGE,
        MODE_ERASE_CONF,
        MODE_ALL_CONF,
        MODE_LOCK_CONF
    } fcs_mode_t;

    typedef struct packed {
        fcs_mode_t                        mode;
        logic                             ready;
        logic                             err_excess;
        logic                             err_prog;
        logic                             err_erase;
        fcs_op_t                          op;
        logic [BLK_W-1:0]                 blk;
        logic [7:0]                       count;
        logic [ADDR_W-1:0]                page_addr;
        logic [NUM_BLOCKS-1:0]            mask;
        logic                             start;
        logic [15:0]                      rdata;
        logic                             rvalid;
        logic                             rst_prev;
        logic [PAGE_WORDS-1:0][15:0]      page;
    } fcs_state_t;

    localparam fcs_state_t FCS_INIT = '{mode: MODE_ARRAY, ready: 1'b1, op: OP_PROGRAM,
                                        default: '0};

    typedef struct packed {
        logic [NUM_BLOCKS-1:0] bits;
    } fcs_lock_state_t;

    localparam logic [NUM_BLOCKS-1:0] LOCK_RESET = '1;

endpackage

// *** verilog/fcs_lock_store.sv ***
// per-block lock bits of the flash command sequencer
// assumes set and clear masks come from the sequencer on the same clock
`timescale 1ns/100ps
module fcs_lock_store
    import fcs_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic [NUM_BLOCKS-1:0] set_mask,
    input  wire logic [NUM_BLOCKS-1:0] clear_mask,
    output      logic [NUM_BLOCKS-1:0] lock_state
);

    fcs_lock_state_t            s;
    fcs_lock_state_t            next_s;
    wire logic [NUM_BLOCKS-1:0] next_bits;

    // stands in for nonvolatile cells; a real macro would load them at power-up
    genvar i;
    generate
        for (i = 0; i < NUM_BLOCKS; i++) begin : g_bit
            // only a finished erase sets, only a lock program clears
            assign next_bits[i] = set_mask[i] ? 1'b1 :
                                  clear_mask[i] ? 1'b0 : s.bits[i];
        end
    endgenerate

    always_comb begin
        next_s      = s;
        next_s.bits = next_bits;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s.bits <= LOCK_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign lock_state = s.bits;

endmodule

// *** verilog/fcs_sequencer.sv ***
// command decoder, status register and write state machine front end
// assumes array reads are addressed by bus_addr directly and answered in the same cycle
`timescale 1ns/100ps
module fcs_sequencer
    import fcs_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    bus_write,
    input  wire logic                    bus_read,
    input  wire logic [ADDR_W-1:0]       bus_addr,
    input  wire logic [15:0]             bus_wdata,
    output      logic [15:0]             bus_rdata,
    output      logic                    bus_rvalid,
    input  wire logic [15:0]             array_rdata,
    input  wire logic                    lock_disable_bit,
    input  wire logic                    controller_reset_bit,
    output      logic                    ready_busy_mirror_bit,
    output      logic                    core_start,
    output      fcs_op_t                 core_op,
    output      logic [BLK_W-1:0]        core_block,
    output      logic [NUM_BLOCKS-1:0]   core_block_mask,
    output      logic [ADDR_W-1:0]       core_page_addr,
    input  wire logic [PAGE_IDX_W-1:0]   core_word_index,
    output      logic [15:0]             core_word_data,
    input  wire logic                    core_done,
    input  wire logic                    core_fail,
    input  wire logic                    core_excess,
    output      logic                    core_abort
);

    fcs_state_t             s;
    fcs_state_t             next_s;
    logic [7:0]             status;
    logic [CODE_W-1:0]      code;
    logic [BLK_W-1:0]       blk;
    logic                   blk_locked;
    logic [NUM_BLOCKS-1:0]  lock_state;
    logic [NUM_BLOCKS-1:0]  lock_set;
    logic [NUM_BLOCKS-1:0]  lock_clr;
    logic                   first_cycle;
    logic                   write_ok;

    fcs_lock_store u_locks (
        .clk        (clk),
        .reset      (reset),
        .set_mask   (lock_set),
        .clear_mask (lock_clr),
        .lock_state (lock_state)
    );

    // reserved bits are constant zero
    always_comb begin
        status                = '0;
        status[ST_READY_BIT]  = s.ready;
        status[ST_ERASE_BIT]  = s.err_erase;
        status[ST_PROG_BIT]   = s.err_prog;
        status[ST_EXCESS_BIT] = s.err_excess;
    end

    assign code        = bus_wdata[CODE_W-1:0];
    assign blk         = bus_addr[ADDR_W-1:BLOCK_SHIFT];
    assign blk_locked  = !lock_state[blk] && !lock_disable_bit;
    assign write_ok    = bus_write && !bus_addr[0];
    assign first_cycle = (s.mode == MODE_ARRAY) || (s.mode == MODE_STATUS) ||
                         (s.mode == MODE_LOCK);
    assign core_abort  = s.rst_prev && !controller_reset_bit;

    always_comb begin
        next_s          = s;
        next_s.start    = 1'b0;
        next_s.rvalid   = 1'b0;
        next_s.rst_prev = controller_reset_bit;
        lock_set        = '0;
        lock_clr        = '0;

        if (bus_read) begin
            next_s.rvalid = 1'b1;
            case (s.mode)
                MODE_ARRAY: begin
                    next_s.rdata = array_rdata;
                end
                MODE_LOCK: begin
                    next_s.rdata                = '0;
                    next_s.rdata[LOCK_DATA_BIT] = lock_state[blk];
                end
                default: begin
                    next_s.rdata = {8'h00, status};
                end
            endcase
        end

        if (!s.ready) begin
            // commands while busy are dropped; the host is to wait for ready
            if (core_done) begin
                next_s.ready = 1'b1;
                case (s.op)
                    OP_PROGRAM: begin
                        // a repeat program of a programmed page reports no error
                        if (core_fail) next_s.err_prog = 1'b1;
                        if (core_excess) next_s.err_excess = 1'b1;
                    end
                    OP_LOCK: begin
                        if (core_fail) begin
                            next_s.err_prog = 1'b1;
                        end else begin
                            lock_clr[s.blk] = 1'b1;
                        end
                    end
                    default: begin
                        if (core_fail) begin
                            next_s.err_erase = 1'b1;
                        end else begin
                            lock_set = s.mask;
                        end
                    end
                endcase
            end
        end else if (write_ok) begin
            case (s.mode)
                MODE_PAGE: begin
                    next_s.page[bus_addr[PAGE_IDX_W:1]] = bus_wdata;
                    next_s.count = s.count + 8'h01;
                    if (s.count == '0) begin
                        next_s.page_addr = {bus_addr[ADDR_W-1:PAGE_SHIFT], 8'h00};
                        next_s.blk       = blk;
                    end
                    if (s.count == PAGE_LAST) begin
                        next_s.mode = MODE_STATUS;
                        if (blk_locked) begin
                            next_s.err_prog = 1'b1;
                        end else begin
                            next_s.start = 1'b1;
                            next_s.ready = 1'b0;
                            next_s.op    = OP_PROGRAM;
                        end
                    end
                end
                MODE_ERASE_CONF, MODE_ALL_CONF, MODE_LOCK_CONF: begin
                    if (code == CMD_CONFIRM) begin
                        next_s.mode = MODE_STATUS;
                        next_s.blk  = blk;
                        if (s.mode == MODE_ALL_CONF) begin
                            next_s.op    = OP_ERASE;
                            next_s.mask  = lock_disable_bit ? '1 : lock_state;
                            next_s.start = 1'b1;
                            next_s.ready = 1'b0;
                        end else if (s.mode == MODE_LOCK_CONF) begin
                            next_s.op    = OP_LOCK;
                            next_s.start = 1'b1;
                            next_s.ready = 1'b0;
                        end else if (blk_locked) begin
                            next_s.err_erase = 1'b1;
                        end else begin
                            next_s.op      = OP_ERASE;
                            next_s.mask    = '0;
                            next_s.mask[blk] = 1'b1;
                            next_s.start   = 1'b1;
                            next_s.ready   = 1'b0;
                        end
                    end else if (code == CMD_READ_ARRAY) begin
                        next_s.mode = MODE_ARRAY;
                    end else begin
                        next_s.mode      = MODE_STATUS;
                        next_s.err_erase = 1'b1;
                        next_s.err_prog  = 1'b1;
                    end
                end
                default: begin
                    case (code)
                        CMD_READ_ARRAY:  next_s.mode = MODE_ARRAY;
                        CMD_READ_STATUS: next_s.mode = MODE_STATUS;
                        CMD_READ_LOCK:   next_s.mode = MODE_LOCK;
                        CMD_CLEAR_STAT: begin
                            next_s.err_erase  = 1'b0;
                            next_s.err_prog   = 1'b0;
                            next_s.err_excess = 1'b0;
                        end
                        CMD_PAGE_PROG: begin
                            next_s.mode  = MODE_PAGE;
                            next_s.count = '0;
                        end
                        CMD_BLOCK_ERASE: next_s.mode = MODE_ERASE_CONF;
                        CMD_ERASE_ALL:   next_s.mode = MODE_ALL_CONF;
                        CMD_LOCK_PROG:   next_s.mode = MODE_LOCK_CONF;
                        default: begin
                            next_s.mode      = MODE_STATUS;
                            next_s.err_erase = 1'b1;
                            next_s.err_prog  = 1'b1;
                        end
                    endcase
                end
            endcase
        end

        // controller reset aborts any operation; the page buffer is left alone
        if (core_abort) begin
            next_s.mode       = MODE_ARRAY;
            next_s.ready      = 1'b1;
            next_s.err_erase  = 1'b0;
            next_s.err_prog   = 1'b0;
            next_s.err_excess = 1'b0;
            next_s.start      = 1'b0;
            next_s.count      = '0;
            lock_set          = '0;
            lock_clr          = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= FCS_INIT;
        end else begin
            s <= next_s;
        end
    end

    assign bus_rdata             = s.rdata;
    assign bus_rvalid            = s.rvalid;
    assign ready_busy_mirror_bit = s.ready;
    assign core_start            = s.start;
    assign core_op               = s.op;
    assign core_block            = s.blk;
    assign core_block_mask       = s.mask;
    assign core_page_addr        = s.page_addr;
    assign core_word_data        = s.page[core_word_index];

    busy_low_a: assert property (@(posedge clk) disable iff (reset)
        s.start |-> !ready_busy_mirror_bit && !status[ST_READY_BIT])
        else $error("ready high while an operation starts");

    ready_rise_a: assert property (@(posedge clk) disable iff (reset)
        (!s.ready && core_done) |=> status[ST_READY_BIT])
        else $error("ready did not rise after done");

    ready_cause_a: assert property (@(posedge clk) disable iff (reset)
        $fell(s.ready) |-> s.start)
        else $error("ready fell without an operation start");

    ctl_reset_a: assert property (@(posedge clk) disable iff (reset)
        core_abort |=> (status == STATUS_RESET) && (s.mode == MODE_ARRAY))
        else $error("controller reset left status not at reset value");

    clear_status_a: assert property (@(posedge clk) disable iff (reset)
        (s.ready && write_ok && first_cycle && code == CMD_CLEAR_STAT)
        |=> status[ST_ERASE_BIT:ST_EXCESS_BIT] == 3'b000)
        else $error("clear status left error bits set");

    read_status_a: assert property (@(posedge clk) disable iff (reset)
        (bus_read && s.mode == MODE_STATUS)
        |=> bus_rvalid && bus_rdata == {8'h00, $past(status)})
        else $error("status read returned wrong data");

    read_lock_a: assert property (@(posedge clk) disable iff (reset)
        (bus_read && s.mode == MODE_LOCK)
        |=> bus_rdata[LOCK_DATA_BIT] == $past(lock_state[blk]))
        else $error("lock read returned wrong bit");

    page_start_a: assert property (@(posedge clk) disable iff (reset)
        (s.ready && write_ok && s.mode == MODE_PAGE && s.count == PAGE_LAST &&
         !blk_locked && !core_abort) |=> core_start ##1 !core_start)
        else $error("page program did not start after last word");

    seq_error_a: assert property (@(posedge clk) disable iff (reset)
        (s.ready && write_ok && !core_abort && s.mode == MODE_ALL_CONF &&
         code != CMD_CONFIRM && code != CMD_READ_ARRAY)
        |=> status[ST_ERASE_BIT] && status[ST_PROG_BIT] && !core_start)
        else $error("bad second cycle not flagged");

    reserved_a: assert property (@(posedge clk) disable iff (reset)
        bus_rvalid && $past(s.mode) == MODE_STATUS |-> bus_rdata[2:0] == 3'b000 &&
        !bus_rdata[LOCK_DATA_BIT])
        else $error("reserved status bit read nonzero");

    ready_hold_a: assert property (@(posedge clk) disable iff (reset)
        $rose(s.ready) |-> $past(core_done || core_abort))
        else $error("ready rose without done or controller reset");

    busy_hold_a: assert property (@(posedge clk) disable iff (reset)
        (!s.ready && !core_done && !core_abort) |=> !ready_busy_mirror_bit)
        else $error("ready rose while the operation still ran");

    busy_read_a: assert property (@(posedge clk) disable iff (reset)
        (bus_read && !s.ready) |=> bus_rvalid && !bus_rdata[ST_READY_BIT])
        else $error("read during busy did not show busy status");

    excess_set_a: assert property (@(posedge clk) disable iff (reset)
        (!s.ready && core_done && s.op == OP_PROGRAM && core_excess && !core_abort)
        |=> status[ST_EXCESS_BIT])
        else $error("excessive write not flagged");

    prog_error_a: assert property (@(posedge clk) disable iff (reset)
        (!s.ready && core_done && s.op != OP_ERASE && core_fail && !core_abort)
        |=> status[ST_PROG_BIT])
        else $error("program failure not flagged");

    erase_error_a: assert property (@(posedge clk) disable iff (reset)
        (!s.ready && core_done && s.op == OP_ERASE && core_fail && !core_abort)
        |=> status[ST_ERASE_BIT])
        else $error("erase failure not flagged");

    lock_clear_a: assert property (@(posedge clk) disable iff (reset)
        (!s.ready && core_done && s.op == OP_LOCK && !core_fail && !core_abort)
        |=> !lock_state[$past(s.blk)])
        else $error("lock program did not lock the block");

    erase_unlock_a: assert property (@(posedge clk) disable iff (reset)
        (!s.ready && core_done && s.op == OP_ERASE && !core_fail && !core_abort)
        |=> (lock_state & $past(s.mask)) == $past(s.mask))
        else $error("erased block left locked");

    locked_prog_a: assert property (@(posedge clk) disable iff (reset)
        (s.ready && write_ok && s.mode == MODE_PAGE && s.count == PAGE_LAST &&
         blk_locked && !core_abort) |=> status[ST_PROG_BIT] && !core_start)
        else $error("program of a locked block not refused");

    array_read_a: assert property (@(posedge clk) disable iff (reset)
        (bus_read && s.mode == MODE_ARRAY) |=> bus_rvalid && bus_rdata == $past(array_rdata))
        else $error("array read returned wrong data");

endmodule

// *** tb/fcs_core_model.sv ***
// behavioural flash array macro facing the sequencer's core port
// assumes one operation at a time; fail and excess are chosen by the bench
`timescale 1ns/100ps
module fcs_core_model
    import fcs_pkg::*;
#(
    parameter int DLY = 140
)
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  core_start,
    input  wire logic                  core_abort,
    input  wire logic [15:0]           core_word_data,
    input  wire logic                  fail_sel,
    input  wire logic                  excess_sel,
    output      logic [PAGE_IDX_W-1:0] core_word_index,
    output      logic                  core_done,
    output      logic                  core_fail,
    output      logic                  core_excess,
    output      logic [15:0]           last_word
);
    logic       busy;
    logic [8:0] cnt;

    // the index sweeps the whole page while busy; DLY must be at least 127
    assign core_word_index = cnt[PAGE_IDX_W-1:0];
    assign core_done       = busy && (cnt == 9'(DLY));
    // while busy before done the qualifiers toggle so a stale value is never trusted
    assign core_fail       = core_done ? fail_sel : cnt[0];
    assign core_excess     = core_done ? excess_sel : ~cnt[0];

    always_ff @(posedge clk) begin
        if (reset || core_abort) begin
            busy <= 1'b0;
            cnt  <= '0;
        end else if (core_start) begin
            busy <= 1'b1;
            cnt  <= '0;
        end else if (core_done) begin
            busy <= 1'b0;
        end else if (busy) begin
            cnt <= cnt + 9'h1;
        end
        if (busy && cnt == 9'h07f) begin
            last_word <= core_word_data;
        end
    end
endmodule

// *** tb/fcs_sequencer_tb_top.sv ***
// self-checking bench for the flash command sequencer
// assumes the array macro model in fcs_core_model and a 200 MHz clock
`timescale 1ns/100ps
module fcs_sequencer_tb_top
    import fcs_pkg::*;
;
    logic                  clk, reset, bus_write, bus_read, bus_rvalid;
    logic                  lock_disable_bit, controller_reset_bit, fail_sel, excess_sel;
    logic                  ready_busy_mirror_bit, core_start, core_done, core_fail;
    logic                  core_excess, core_abort;
    logic [ADDR_W-1:0]     bus_addr;
    logic [15:0]           bus_wdata, bus_rdata, array_rdata, core_word_data, last_word;
    logic [PAGE_IDX_W-1:0] core_word_index;
    logic [1:0]            core_op;
    logic [BLK_W-1:0]      core_block;
    logic [NUM_BLOCKS-1:0] core_block_mask;
    logic [ADDR_W-1:0]     core_page_addr;
    int                    n_errors, n_tests, cyc;

    // array contents are a fixed scramble of the address
    assign array_rdata = bus_addr[15:0] ^ 16'h5a5a;

    fcs_sequencer i_fcs_sequencer (.clk(clk), .reset(reset), .bus_write(bus_write),
        .bus_read(bus_read), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .array_rdata(array_rdata),
        .lock_disable_bit(lock_disable_bit), .controller_reset_bit(controller_reset_bit),
        .ready_busy_mirror_bit(ready_busy_mirror_bit), .core_start(core_start),
        .core_op(core_op), .core_block(core_block), .core_block_mask(core_block_mask),
        .core_page_addr(core_page_addr),
        .core_word_index(core_word_index), .core_word_data(core_word_data),
        .core_done(core_done), .core_fail(core_fail), .core_excess(core_excess),
        .core_abort(core_abort));

    fcs_core_model #(.DLY(140)) i_fcs_core_model (.clk(clk), .reset(reset),
        .core_start(core_start), .core_abort(core_abort), .core_word_data(core_word_data),
        .fail_sel(fail_sel), .excess_sel(excess_sel), .core_word_index(core_word_index),
        .core_done(core_done), .core_fail(core_fail), .core_excess(core_excess),
        .last_word(last_word));

    always #2.5 clk = ~clk;

    task automatic test_done();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // the run is well under 20000 cycles; a hang ends here
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one write per call; the leading edge keeps strobes from toggling twice in one step
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge clk);
        bus_write <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp, input string nm);
        @(posedge clk);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge clk);
        bus_read <= 1'b0;
        // rvalid stands for this one cycle only
        #1;
        chk("rvalid", 16'h1, {15'h0, bus_rvalid});
        chk(nm, exp, bus_rdata);
    endtask

    task automatic stat(input logic [15:0] exp);
        wr('0, 16'h0070);
        rd('0, exp, "status");
    endtask

    // busy must show on the mirror, then ready within a bounded wait
    task automatic busy_done(input logic [15:0] exp);
        @(posedge clk);
        #1;
        chk("busy", 16'h0, {15'h0, ready_busy_mirror_bit});
        repeat (400) begin
            @(posedge clk);
            if (ready_busy_mirror_bit === 1'b1) break;
        end
        #1;
        chk("ready", 16'h1, {15'h0, ready_busy_mirror_bit});
        rd('0, exp, "status");
    endtask

    task automatic page(input logic [10:0] pg);
        wr({pg, 8'h00}, 16'h0041);
        for (int i = 0; i < 128; i++) begin
            wr({pg, 7'(i), 1'b0}, 16'h1000 + 16'(i));
        end
    endtask

    function automatic logic [ADDR_W-1:0] top(input logic [2:0] b);
        return {b, BLOCK_TOP_OFS};
    endfunction

    initial begin
        clk = 0; reset = 1; bus_write = 0; bus_read = 0; bus_addr = '0; bus_wdata = '0;
        lock_disable_bit = 0; controller_reset_bit = 0; fail_sel = 0; excess_sel = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("mirror", 16'h1, {15'h0, ready_busy_mirror_bit});
        stat(16'h0080);
        wr('0, 16'h12ff);
        rd(19'h00124, 16'h0124 ^ 16'h5a5a, "array");
        rd(19'h10ffe, 16'h0ffe ^ 16'h5a5a, "array");
        wr('0, 16'h0000);
        stat(16'h00b0);
        wr('0, 16'h0050);
        stat(16'h0080);
        excess_sel <= 1'b1;
        page({3'd1, 8'h20});
        busy_done(16'h0088);
        chk("page word", 16'h107f, last_word);
        chk("op", 16'h0000, {14'h0, core_op});
        chk("page base", 16'h2000, core_page_addr[15:0]);
        chk("block", 16'h0001, {13'h0, core_block});
        excess_sel <= 1'b0;
        wr('0, 16'h0050);
        page({3'd1, 8'h20});
        busy_done(16'h0080);
        wr('0, 16'h0077);
        wr(top(3'd2), 16'hffd0);
        busy_done(16'h0080);
        chk("op", 16'h0002, {14'h0, core_op});
        chk("block", 16'h0002, {13'h0, core_block});
        wr('0, 16'h0071);
        rd(top(3'd2), 16'h0000, "lock");
        rd(top(3'd3), 16'h0040, "lock");
        page({3'd2, 8'h40});
        @(posedge clk);
        #1;
        chk("no start", 16'h1, {15'h0, ready_busy_mirror_bit});
        stat(16'h0090);
        wr('0, 16'h0050);
        lock_disable_bit <= 1'b1;
        wr('0, 16'h0071);
        rd(top(3'd2), 16'h0000, "lock");
        wr('0, 16'h0020);
        wr(top(3'd2), 16'h00d0);
        busy_done(16'h0080);
        chk("op", 16'h0001, {14'h0, core_op});
        chk("mask", 16'h0004, {8'h00, core_block_mask});
        @(posedge clk);
        lock_disable_bit <= 1'b0;
        wr('0, 16'h0071);
        rd(top(3'd2), 16'h0040, "lock");
        fail_sel <= 1'b1;
        wr('0, 16'h00a7);
        wr('0, 16'h00d0);
        busy_done(16'h00a0);
        chk("mask", 16'h00ff, {8'h00, core_block_mask});
        wr('0, 16'h0050);
        wr('0, 16'h0077);
        wr(top(3'd4), 16'h00d0);
        busy_done(16'h0090);
        fail_sel <= 1'b0;
        wr('0, 16'h0050);
        wr('0, 16'h0020);
        wr(top(3'd3), 16'h0055);
        stat(16'h00b0);
        wr('0, 16'h0050);
        wr('0, 16'h0077);
        wr(top(3'd3), 16'h00ff);
        rd(19'h30010, 16'h0010 ^ 16'h5a5a, "array");
        stat(16'h0080);
        wr('0, 16'h0000);
        wr('0, 16'h0020);
        wr(top(3'd5), 16'h00d0);
        @(posedge clk);
        #1;
        chk("busy", 16'h0, {15'h0, ready_busy_mirror_bit});
        @(posedge clk);
        controller_reset_bit <= 1'b1;
        @(posedge clk);
        controller_reset_bit <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("ctl reset", 16'h1, {15'h0, ready_busy_mirror_bit});
        stat(16'h0080);
        test_done();
    end
endmodule
